// ---- inc/pbca_pkg.sv ----
// Purpose: Shared constants and types of the pin B converter assignment block
// Assumes: 8-bit register port, one clock
// Notes:   Pin-selected voltage code VOLT_OFF selects a converter off

package pbca_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] ASSIGN_OFFSET = 8'h48;
    localparam logic [DATA_W-1:0] ASSIGN_RESET = 8'h00;
    localparam logic [DATA_W-1:0] ASSIGN_RW_MASK = 8'h1f;
    localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int BIT_IO = 0;
    localparam int BIT_CORE_A = 1;
    localparam int BIT_CORE_B = 2;
    localparam int BIT_FET = 3;
    localparam int BIT_SPARE = 4;
    localparam int CONV_N = 4;

    // ----------------------------------------
    // Converter voltage and mode
    // ----------------------------------------
    localparam int VOLT_W = 8;
    localparam logic [VOLT_W-1:0] VOLT_OFF = 8'h00;

    typedef enum logic [1:0] {
        mode_off,
        mode_active,
        mode_low_power
    } pbca_mode_t;

    // ----------------------------------------
    // Synchroniser
    // ----------------------------------------
    localparam logic [1:0] SYNC_SETTLED = 2'h2;
    localparam logic [1:0] SYNC_STEP = 2'h1;
    localparam logic [1:0] SYNC_START = 2'h0;

endpackage

// ---- hw/pbca_conv_sel.sv ----
// Purpose: Picks voltage and mode of one converter from pin or registers
// Assumes: Pin input already synchronised to i_clk
// Notes:   IO_STYLE converters have no pin-selected voltage

`timescale 1ns/1ps

module pbca_conv_sel
    import pbca_pkg::*;
#(
    parameter int VW = VOLT_W,
    parameter bit IO_STYLE = 1'b0
)
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_assign,
    input wire logic i_pin,
    input wire logic i_keep_on,
    input wire logic [VW-1:0] i_op_voltage,
    input wire logic [VW-1:0] i_sleep_voltage,
    input wire logic [VW-1:0] i_reg_voltage,
    input wire pbca_mode_t i_reg_mode,
    output logic [VW-1:0] o_voltage,
    output pbca_mode_t o_mode
);

    // ----------------------------------------
    // Selection
    // ----------------------------------------
    wire op_off = (i_op_voltage == VW'(VOLT_OFF));
    wire sleep_off = (i_sleep_voltage == VW'(VOLT_OFF));
    wire pbca_mode_t high_mode = (!IO_STYLE && op_off) ? mode_off : mode_active;
    wire pbca_mode_t sleep_awake = IO_STYLE ? mode_off : mode_active;
    wire pbca_mode_t low_mode = (!IO_STYLE && sleep_off) ? mode_off
        : (i_keep_on ? mode_low_power : sleep_awake);
    wire pbca_mode_t next_mode = !i_assign ? i_reg_mode : (i_pin ? high_mode : low_mode);
    wire [VW-1:0] pin_voltage = i_pin ? i_op_voltage : i_sleep_voltage;
    wire [VW-1:0] next_voltage = (!i_assign || IO_STYLE) ? i_reg_voltage : pin_voltage;

    // ----------------------------------------
    // Output flops
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_voltage <= VW'(VOLT_OFF);
            o_mode <= mode_off;
        end
        else
        begin
            o_voltage <= next_voltage;
            o_mode <= next_mode;
        end
    end

endmodule // pbca_conv_sel

// ---- hw/pbca_pin_b_assign.sv ----
// Purpose: Pin B converter assignment register and converter control
// Assumes: i_resetn is the turn-off reset; register port on i_clk
// Notes:   Outputs follow the pin three edges after it changes
//
// Function
// - Any of the four converter assignment bits set disables serial interface; the spare bit does not
// - Unassigned converter follows register-driven control only
// - FET controller, pin high: operating voltage register
// - FET controller, pin low: sleep voltage register
// - FET controller, pin low, keep-on: low power
// - Core B assigned: pin picks operating or sleep
// - Core B, pin low, keep-on: low power
// - Core A assigned: pin picks operating or sleep
// - Core A, pin low, keep-on: low power
// - IO converter assigned, pin high: on
// - IO converter, pin low: off or low power
// - Register clears only on turn-off reset

`timescale 1ns/1ps

module pbca_pin_b_assign
    import pbca_pkg::*;
#(
    parameter int VW = VOLT_W
)
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [ADDR_W-1:0] i_reg_addr,
    input wire logic [DATA_W-1:0] i_reg_wdata,
    output logic [DATA_W-1:0] o_reg_rdata,
    input wire logic i_second_enable_pin,
    input wire logic [CONV_N-1:0] i_sleep_keep_on_settings,
    input wire logic [VW-1:0] i_fet_ctrl_operating_voltage,
    input wire logic [VW-1:0] i_fet_ctrl_sleep_voltage,
    input wire logic [VW-1:0] i_core_a_operating_voltage,
    input wire logic [VW-1:0] i_core_a_sleep_voltage,
    input wire logic [VW-1:0] i_core_b_operating_voltage,
    input wire logic [VW-1:0] i_core_b_sleep_voltage,
    input wire logic [VW-1:0] i_fet_ctrl_reg_voltage,
    input wire logic [VW-1:0] i_core_a_reg_voltage,
    input wire logic [VW-1:0] i_core_b_reg_voltage,
    input wire logic [VW-1:0] i_io_reg_voltage,
    input wire pbca_mode_t i_fet_ctrl_reg_mode,
    input wire pbca_mode_t i_core_a_reg_mode,
    input wire pbca_mode_t i_core_b_reg_mode,
    input wire pbca_mode_t i_io_reg_mode,
    output logic [VW-1:0] o_fet_ctrl_voltage,
    output logic [VW-1:0] o_core_a_voltage,
    output logic [VW-1:0] o_core_b_voltage,
    output logic [VW-1:0] o_io_voltage,
    output pbca_mode_t o_fet_ctrl_mode,
    output pbca_mode_t o_core_a_mode,
    output pbca_mode_t o_core_b_mode,
    output pbca_mode_t o_io_mode,
    output logic o_sr_if_disable
);

    // ----------------------------------------
    // Pin synchroniser
    // ----------------------------------------
    logic pin_meta;
    logic pin_sync;

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
        end
        else
        begin
            pin_meta <= i_second_enable_pin;
            pin_sync <= pin_meta;
        end
    end

    // ----------------------------------------
    // Assignment register
    // ----------------------------------------
    logic [DATA_W-1:0] assign_reg;
    logic [DATA_W-1:0] reg_rdata;
    logic sr_disable;

    wire addr_hit = (i_reg_addr == ASSIGN_OFFSET);
    wire write_hit = i_reg_wr && addr_hit;
    wire read_hit = i_reg_rd && addr_hit;
    wire [DATA_W-1:0] next_assign = write_hit ? (i_reg_wdata & ASSIGN_RW_MASK) : assign_reg;
    wire next_sr_disable = next_assign[BIT_FET] || next_assign[BIT_CORE_B]
        || next_assign[BIT_CORE_A] || next_assign[BIT_IO];
    wire [DATA_W-1:0] next_rdata = read_hit ? assign_reg : READ_ZERO;

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            assign_reg <= ASSIGN_RESET;
            sr_disable <= 1'b0;
            reg_rdata <= READ_ZERO;
        end
        else
        begin
            assign_reg <= next_assign;
            sr_disable <= next_sr_disable;
            reg_rdata <= next_rdata;
        end
    end

    assign o_reg_rdata = reg_rdata;
    assign o_sr_if_disable = sr_disable;

    // ----------------------------------------
    // Converter selectors
    // ----------------------------------------
    pbca_conv_sel #(.VW(VW), .IO_STYLE(1'b0)) u_fet_ctrl
    (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_assign(assign_reg[BIT_FET]),
        .i_pin(pin_sync),
        .i_keep_on(i_sleep_keep_on_settings[BIT_FET]),
        .i_op_voltage(i_fet_ctrl_operating_voltage),
        .i_sleep_voltage(i_fet_ctrl_sleep_voltage),
        .i_reg_voltage(i_fet_ctrl_reg_voltage),
        .i_reg_mode(i_fet_ctrl_reg_mode),
        .o_voltage(o_fet_ctrl_voltage),
        .o_mode(o_fet_ctrl_mode)
    );

    pbca_conv_sel #(.VW(VW), .IO_STYLE(1'b0)) u_core_b
    (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_assign(assign_reg[BIT_CORE_B]),
        .i_pin(pin_sync),
        .i_keep_on(i_sleep_keep_on_settings[BIT_CORE_B]),
        .i_op_voltage(i_core_b_operating_voltage),
        .i_sleep_voltage(i_core_b_sleep_voltage),
        .i_reg_voltage(i_core_b_reg_voltage),
        .i_reg_mode(i_core_b_reg_mode),
        .o_voltage(o_core_b_voltage),
        .o_mode(o_core_b_mode)
    );

    pbca_conv_sel #(.VW(VW), .IO_STYLE(1'b0)) u_core_a
    (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_assign(assign_reg[BIT_CORE_A]),
        .i_pin(pin_sync),
        .i_keep_on(i_sleep_keep_on_settings[BIT_CORE_A]),
        .i_op_voltage(i_core_a_operating_voltage),
        .i_sleep_voltage(i_core_a_sleep_voltage),
        .i_reg_voltage(i_core_a_reg_voltage),
        .i_reg_mode(i_core_a_reg_mode),
        .o_voltage(o_core_a_voltage),
        .o_mode(o_core_a_mode)
    );

    pbca_conv_sel #(.VW(VW), .IO_STYLE(1'b1)) u_io
    (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_assign(assign_reg[BIT_IO]),
        .i_pin(pin_sync),
        .i_keep_on(i_sleep_keep_on_settings[BIT_IO]),
        .i_op_voltage(i_io_reg_voltage),
        .i_sleep_voltage(i_io_reg_voltage),
        .i_reg_voltage(i_io_reg_voltage),
        .i_reg_mode(i_io_reg_mode),
        .o_voltage(o_io_voltage),
        .o_mode(o_io_mode)
    );

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    logic [1:0] sync_age;

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            sync_age <= SYNC_START;
        end
        else if (sync_age != SYNC_SETTLED)
        begin
            sync_age <= 2'(sync_age + SYNC_STEP);
        end
    end

    sr_disable_a:
    assert property (@(posedge i_clk) disable iff (!i_resetn)
        write_hit |=> o_sr_if_disable == ($past(i_reg_wdata[BIT_FET:BIT_IO]) != 4'h0))
    else $error("serial interface disable wrong after write");

    core_a_free_a:
    assert property (@(posedge i_clk) disable iff (!i_resetn)
        !assign_reg[BIT_CORE_A] |=> o_core_a_voltage == $past(i_core_a_reg_voltage)
            && o_core_a_mode == $past(i_core_a_reg_mode))
    else $error("unassigned core A not following registers");

    fet_high_a:
    assert property (@(posedge i_clk) disable iff (!i_resetn)
        assign_reg[BIT_FET] && pin_sync |=> o_fet_ctrl_voltage == $past(i_fet_ctrl_operating_voltage))
    else $error("FET controller not on operating voltage");

    fet_low_a:
    assert property (@(posedge i_clk) disable iff (!i_resetn)
        assign_reg[BIT_FET] && !pin_sync && i_fet_ctrl_sleep_voltage == VW'(VOLT_OFF)
            |=> o_fet_ctrl_voltage == VW'(VOLT_OFF) && o_fet_ctrl_mode == mode_off)
    else $error("FET controller not off from sleep register");

    fet_keep_on_a:
    assert property (@(posedge i_clk) disable iff (!i_resetn)
        assign_reg[BIT_FET] && !pin_sync && i_sleep_keep_on_settings[BIT_FET]
            && i_fet_ctrl_sleep_voltage != VW'(VOLT_OFF) |=> o_fet_ctrl_mode == mode_low_power)
    else $error("FET controller not in low power");

    core_b_select_a:
    assert property (@(posedge i_clk) disable iff (!i_resetn)
        assign_reg[BIT_CORE_B] |=> o_core_b_voltage == ($past(pin_sync)
            ? $past(i_core_b_operating_voltage) : $past(i_core_b_sleep_voltage)))
    else $error("core B voltage source wrong");

    core_b_keep_on_a:
    assert property (@(posedge i_clk) disable iff (!i_resetn)
        assign_reg[BIT_CORE_B] && !pin_sync && i_sleep_keep_on_settings[BIT_CORE_B]
            && i_core_b_sleep_voltage != VW'(VOLT_OFF) |=> o_core_b_mode == mode_low_power)
    else $error("core B not in low power");

    core_a_select_a:
    assert property (@(posedge i_clk) disable iff (!i_resetn)
        assign_reg[BIT_CORE_A] && !pin_sync |=> o_core_a_voltage == $past(i_core_a_sleep_voltage))
    else $error("core A not on sleep voltage");

    core_a_keep_on_a:
    assert property (@(posedge i_clk) disable iff (!i_resetn)
        assign_reg[BIT_CORE_A] && !pin_sync && i_sleep_keep_on_settings[BIT_CORE_A]
            && i_core_a_sleep_voltage != VW'(VOLT_OFF) |=> o_core_a_mode == mode_low_power)
    else $error("core A not in low power");

    io_high_a:
    assert property (@(posedge i_clk) disable iff (!i_resetn)
        assign_reg[BIT_IO] && pin_sync |=> o_io_mode == mode_active)
    else $error("IO converter not on with pin high");

    io_low_a:
    assert property (@(posedge i_clk) disable iff (!i_resetn)
        assign_reg[BIT_IO] && !pin_sync |=> o_io_mode == ($past(i_sleep_keep_on_settings[BIT_IO])
            ? mode_low_power : mode_off))
    else $error("IO converter wrong with pin low");

    reset_clear_a:
    assert property (@(posedge i_clk) disable iff (!i_resetn)
        $rose(sync_age == SYNC_STEP) |-> o_sr_if_disable == 1'b0 && o_reg_rdata == READ_ZERO)
    else $error("assignment not clear after reset");

    pin_sync_a:
    assert property (@(posedge i_clk) disable iff (!i_resetn)
        sync_age == SYNC_SETTLED |-> pin_sync == $past(i_second_enable_pin, 2))
    else $error("pin not passed through two flops");

endmodule // pbca_pin_b_assign

// ---- tb/pbca_host_model.sv ----
// Purpose: Host processor model driving the second enable pin
// Assumes: Level requests come from the bench
// Notes:   Pin moves just after a falling edge
`timescale 1ns/1ps

module pbca_host_model
(
    input wire logic i_clk,
    input wire logic i_level,
    output logic o_second_enable_pin
);
    // ----------------------------------------
    // Pin driver
    // ----------------------------------------
    always @(negedge i_clk)
    begin
        o_second_enable_pin <= i_level;
    end
endmodule // pbca_host_model

// ---- tb/tb.sv ----
// Purpose: Self-checking bench of the pin B converter assignment
// Assumes: Inputs driven at the falling edge
// Notes:   Voltage codes are distinct per source
`timescale 1ns/1ps

module tb;
    import pbca_pkg::*;
    logic i_clk, resetn, wr, rd, level, pin, sr_dis;
    logic [7:0] addr, wdata, rdata, fop, fsl, aop, asl, bop, bsl, frv, arv, brv, irv;
    logic [7:0] fv, av, bv, iv;
    logic [3:0] keep;
    pbca_mode_t rmode, fm, am, bm, im;
    int err_count = 0;
    int tests_run = 0;
    int cycles = 0;
    pbca_host_model i_host (.i_clk(i_clk), .i_level(level), .o_second_enable_pin(pin));
    pbca_pin_b_assign i_dut (.i_clk(i_clk), .i_resetn(resetn), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_second_enable_pin(pin),
        .i_sleep_keep_on_settings(keep), .i_fet_ctrl_operating_voltage(fop),
        .i_fet_ctrl_sleep_voltage(fsl), .i_core_a_operating_voltage(aop), .i_core_a_sleep_voltage(asl),
        .i_core_b_operating_voltage(bop), .i_core_b_sleep_voltage(bsl), .i_fet_ctrl_reg_voltage(frv),
        .i_core_a_reg_voltage(arv), .i_core_b_reg_voltage(brv), .i_io_reg_voltage(irv),
        .i_fet_ctrl_reg_mode(rmode), .i_core_a_reg_mode(rmode), .i_core_b_reg_mode(rmode),
        .i_io_reg_mode(rmode), .o_fet_ctrl_voltage(fv), .o_core_a_voltage(av), .o_core_b_voltage(bv),
        .o_io_voltage(iv), .o_fet_ctrl_mode(fm), .o_core_a_mode(am), .o_core_b_mode(bm),
        .o_io_mode(im), .o_sr_if_disable(sr_dis));

    // ----------------------------------------
    // Clock and timeout
    // ----------------------------------------
    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            err_count++;
            complete_run();
        end
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(negedge i_clk);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge i_clk);
        rd <= 1'b1;
        addr <= a;
        @(negedge i_clk);
        rd <= 1'b0;
        check(rdata, exp);
    endtask
    task automatic chk_conv(input logic [7:0] f, a, b, i, input pbca_mode_t mf, ma, mb, mi);
        check(fv, f);
        check(av, a);
        check(bv, b);
        check(iv, i);
        check(8'(fm), 8'(mf));
        check(8'(am), 8'(ma));
        check(8'(bm), 8'(mb));
        check(8'(im), 8'(mi));
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_unassigned();
        level <= 1'b1;
        wait_n(5);
        chk_conv(frv, arv, brv, irv, rmode, rmode, rmode, rmode);
        level <= 1'b0;
        rmode <= mode_low_power;
        wait_n(5);
        chk_conv(frv, arv, brv, irv, rmode, rmode, rmode, rmode);
        rmode <= mode_active;
    endtask
    task automatic t_regmap();
        reg_wr(8'h48, 8'hff);
        reg_rd(8'h48, 8'h1f);
        for (int k = 0; k < 5; k++)
        begin
            reg_wr(8'h48, 8'h01 << k);
            check({7'h00, sr_dis}, {7'h00, k < 4});
        end
        reg_wr(8'h47, 8'h00);
        reg_rd(8'h47, 8'h00);
        reg_rd(8'h48, 8'h10);
    endtask
    task automatic t_assigned();
        reg_wr(8'h48, 8'h0f);
        level <= 1'b1;
        wait_n(5);
        chk_conv(fop, aop, bop, irv, mode_active, mode_active,
            mode_active, mode_active);
        level <= 1'b0;
        wait_n(5);
        chk_conv(fsl, asl, bsl, irv, mode_active, mode_active, mode_active, mode_off);
        keep <= 4'hf;
        wait_n(2);
        chk_conv(fsl, asl, bsl, irv, mode_low_power, mode_low_power,
            mode_low_power, mode_low_power);
        fsl <= 8'h00;
        asl <= 8'h00;
        bsl <= 8'h00;
        wait_n(2);
        chk_conv(8'h00, 8'h00, 8'h00, irv, mode_off, mode_off, mode_off, mode_low_power);
        fop <= 8'h00;
        level <= 1'b1;
        wait_n(5);
        chk_conv(8'h00, aop, bop, irv, mode_off, mode_active, mode_active, mode_active);
        asl <= 8'h42;
    endtask
    task automatic t_sync();
        level <= 1'b0;
        wait_n(5);
        check(av, asl);
        level <= 1'b1;
        wait_n(1);
        check(av, asl);
        wait_n(2);
        check(av, asl);
        wait_n(1);
        check(av, aop);
    endtask
    task automatic t_reset_mid();
        resetn <= 1'b0;
        wait_n(1);
        check({7'h00, sr_dis}, 8'h00);
        resetn <= 1'b1;
        reg_rd(8'h48, 8'h00);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        {resetn, wr, rd, level, addr, wdata, keep} = '0;
        {fop, fsl, aop, asl, bop, bsl} = {8'h31, 8'h32, 8'h41, 8'h42, 8'h51, 8'h52};
        {frv, arv, brv, irv} = {8'h3a, 8'h4a, 8'h5a, 8'h6a};
        rmode = mode_active;
        wait_n(4);
        resetn <= 1'b1;
        reg_rd(8'h48, 8'h00);
        check({7'h00, sr_dis}, 8'h00);
        t_unassigned();
        t_regmap();
        t_assigned();
        t_sync();
        t_reset_mid();
        complete_run();
    end
endmodule // tb
